// ==== pio_pkg.sv ====
// Shared constants and types for the port I/O block.
package pio_pkg;

    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned PORT_W = 8;
    localparam int unsigned PG_W = 5;
    localparam int unsigned SYNC_W = 21;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [5:0] IDX_C_DIR = 6'h14;
    localparam logic [5:0] IDX_C_OUT = 6'h15;
    localparam logic [5:0] IDX_B_PIN = 6'h16;
    localparam logic [5:0] IDX_B_DIR = 6'h17;
    localparam logic [5:0] IDX_B_OUT = 6'h18;
    localparam logic [5:0] IDX_A_PIN = 6'h19;
    localparam logic [5:0] IDX_A_DIR = 6'h1a;
    localparam logic [5:0] IDX_A_OUT = 6'h1b;
    localparam logic [5:0] IDX_G_CTRL = 6'h20;
    localparam logic [5:0] IDX_G_STAT = 6'h21;

    // Offset from the I/O address to the memory-mapped address.
    localparam logic [7:0] IO_MEM_OFFSET = 8'h20;

    localparam logic [7:0] PORT_RESET = 8'h00;
    localparam logic [4:0] PG_RESET = 5'h00;

    // Field positions in the port G control register.
    localparam int unsigned G_OUT_LSB = 0;
    localparam int unsigned G_DIR_LSB = 8;
    localparam int unsigned ASYNC_BIT = 16;
    localparam int unsigned EXTMEM_BIT = 17;

    // Port G pin positions.
    localparam int unsigned PIN_WR = 0;
    localparam int unsigned PIN_RD = 1;
    localparam int unsigned PIN_ALE = 2;
    localparam int unsigned PIN_OSC_IN = 3;
    localparam int unsigned PIN_OSC_OUT = 4;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [0:0] {
        PIO_WR_IDLE = 1'b0,
        PIO_WR_RESP = 1'b1
    } pio_wr_state_type;

endpackage : pio_pkg

// ==== pio_ovr_if.sv ====
// Override enables and values for the port G pins.
`timescale 1ns/1ps
interface pio_ovr_if;
    logic [4:0] pullup_override_enable;
    logic [4:0] pullup_override_value;
    logic [4:0] direction_override_enable;
    logic [4:0] direction_override_value;
    logic [4:0] pin_value_override_enable;
    logic [4:0] pin_value_override_value;
    logic [4:0] input_gate_override_enable;
    logic [4:0] input_gate_override_value;

    modport src (
        output pullup_override_enable,
        output pullup_override_value,
        output direction_override_enable,
        output direction_override_value,
        output pin_value_override_enable,
        output pin_value_override_value,
        output input_gate_override_enable,
        output input_gate_override_value
    );

    modport dst (
        input pullup_override_enable,
        input pullup_override_value,
        input direction_override_enable,
        input direction_override_value,
        input pin_value_override_enable,
        input pin_value_override_value,
        input input_gate_override_enable,
        input input_gate_override_value
    );
endinterface : pio_ovr_if

// ==== pio_in_sync.sv ====
// Two-stage synchroniser for the pin inputs.
`timescale 1ns/1ps
module pio_in_sync
    import pio_pkg::*;
#(
    parameter int unsigned W = SYNC_W
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [W-1:0] raw,
    output logic [W-1:0] synced
);
    logic [W-1:0] meta_q;

    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
                meta_q[i] <= 1'b0;
                synced[i] <= 1'b0;
            end else begin
                meta_q[i] <= raw[i];
                synced[i] <= meta_q[i];
            end
        end
    end
endmodule : pio_in_sync

// ==== pio_pin_cell.sv ====
// Per-pin override multiplexers for port G.
`timescale 1ns/1ps
module pio_pin_cell
    import pio_pkg::*;
(
    pio_ovr_if.dst ovr,
    input wire logic [PG_W-1:0] base_out,
    input wire logic [PG_W-1:0] base_dir,
    output logic [PG_W-1:0] pin_out,
    output logic [PG_W-1:0] pin_oe,
    output logic [PG_W-1:0] pin_pullup,
    output logic [PG_W-1:0] pin_in_en
);
    for (genvar i = 0; i < PG_W; i++) begin : g_pin
        // The pull-up is only on for an input pin whose latch bit is one.
        assign pin_pullup[i] = ovr.pullup_override_enable[i] ?
            ovr.pullup_override_value[i] : (~base_dir[i] & base_out[i]);
        assign pin_oe[i] = ovr.direction_override_enable[i] ?
            ovr.direction_override_value[i] : base_dir[i];
        assign pin_out[i] = ovr.pin_value_override_enable[i] ?
            ovr.pin_value_override_value[i] : base_out[i];
        assign pin_in_en[i] = ovr.input_gate_override_enable[i] ?
            ovr.input_gate_override_value[i] : 1'b1;
    end
endmodule : pio_pin_cell

// ==== pio_port_top.sv ====
// Port A, B, C registers and port G alternate-function override, AXI4-Lite.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module pio_port_top
    import pio_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [PORT_W-1:0] port_a_in,
    output logic [PORT_W-1:0] port_a_out,
    output logic [PORT_W-1:0] port_a_oe,
    output logic [PORT_W-1:0] port_a_pullup,
    input wire logic [PORT_W-1:0] port_b_in,
    output logic [PORT_W-1:0] port_b_out,
    output logic [PORT_W-1:0] port_b_oe,
    output logic [PORT_W-1:0] port_b_pullup,
    output logic [PORT_W-1:0] port_c_out,
    output logic [PORT_W-1:0] port_c_oe,
    output logic [PORT_W-1:0] port_c_pullup,
    input wire logic [PG_W-1:0] port_g_in,
    output logic [PG_W-1:0] port_g_out,
    output logic [PG_W-1:0] port_g_oe,
    output logic [PG_W-1:0] port_g_pullup,
    output logic [PG_W-1:0] port_g_in_en,
    input wire logic ext_latch_strobe,
    input wire logic ext_read_strobe_b,
    input wire logic ext_write_strobe_b,
    output logic osc_amp_connect
);
    pio_wr_state_type wr_state_q, wr_state_d;
    logic aw_held_q, aw_held_d, w_held_q, w_held_d, wr_do, aw_take, w_take;
    logic ar_take, rvalid_d, rd_hit;
    logic async_timer_clock_select, ext_memory_enable;
    logic [5:0] aw_idx_q;
    logic [DATA_W-1:0] w_data_q;
    logic [3:0] w_strb_q;
    logic [DATA_W-1:0] rd_data_d;
    logic [PORT_W-1:0] a_out_q, a_dir_q, b_out_q, b_dir_q, c_out_q, c_dir_q;
    logic [PG_W-1:0] g_out_q, g_dir_q, g_cell_out, g_cell_oe, g_cell_pullup;
    logic [PG_W-1:0] g_cell_in_en, g_pin_read;
    logic [SYNC_W-1:0] pins_sync;

    pio_ovr_if g_ovr ();

    function automatic logic idx_mapped(input logic [5:0] idx);
        case (idx)
            IDX_C_DIR, IDX_C_OUT, IDX_B_PIN, IDX_B_DIR, IDX_B_OUT,
            IDX_A_PIN, IDX_A_DIR, IDX_A_OUT, IDX_G_CTRL,
            IDX_G_STAT: idx_mapped = 1'b1;
            default: idx_mapped = 1'b0;
        endcase
    endfunction : idx_mapped

    // Write channel: address and data are taken in either order.
    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take = s_axi_wvalid & s_axi_wready;
    assign wr_do = aw_held_q & w_held_q & (wr_state_q == PIO_WR_IDLE);

    always_comb begin
        aw_held_d = wr_do ? 1'b0 : (aw_held_q | aw_take);
        w_held_d = wr_do ? 1'b0 : (w_held_q | w_take);
        case (wr_state_q)
            PIO_WR_IDLE: wr_state_d = wr_do ? PIO_WR_RESP : PIO_WR_IDLE;
            PIO_WR_RESP: begin
                wr_state_d = s_axi_bready ? PIO_WR_IDLE : PIO_WR_RESP;
            end
            default: wr_state_d = PIO_WR_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wr_state_q <= PIO_WR_IDLE;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            wr_state_q <= wr_state_d;
            aw_held_q <= aw_held_d;
            w_held_q <= w_held_d;
            s_axi_awready <= ~aw_held_d & (wr_state_d == PIO_WR_IDLE);
            s_axi_wready <= ~w_held_d & (wr_state_d == PIO_WR_IDLE);
            s_axi_bvalid <= (wr_state_d == PIO_WR_RESP);
            if (wr_do) begin
                s_axi_bresp <= idx_mapped(aw_idx_q) ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            aw_idx_q <= 6'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_idx_q <= s_axi_awaddr[7:2];
            end
            if (w_take) begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
        end
    end

    // Port data and direction registers. Pin input indices fall through,
    // so a write there is answered but stores nothing.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            a_out_q <= PORT_RESET;
            a_dir_q <= PORT_RESET;
            b_out_q <= PORT_RESET;
            b_dir_q <= PORT_RESET;
            c_out_q <= PORT_RESET;
            c_dir_q <= PORT_RESET;
        end else if (wr_do && w_strb_q[0]) begin
            case (aw_idx_q)
                IDX_A_OUT: a_out_q <= w_data_q[7:0];
                IDX_A_DIR: a_dir_q <= w_data_q[7:0];
                IDX_B_OUT: b_out_q <= w_data_q[7:0];
                IDX_B_DIR: b_dir_q <= w_data_q[7:0];
                IDX_C_OUT: c_out_q <= w_data_q[7:0];
                IDX_C_DIR: c_dir_q <= w_data_q[7:0];
                default: a_out_q <= a_out_q;
            endcase
        end
    end

    // Port G base latch, direction and the two alternate-function selects.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            g_out_q <= PG_RESET;
            g_dir_q <= PG_RESET;
            async_timer_clock_select <= 1'b0;
            ext_memory_enable <= 1'b0;
        end else if (wr_do && (aw_idx_q == IDX_G_CTRL)) begin
            if (w_strb_q[0]) begin
                g_out_q <= w_data_q[G_OUT_LSB +: PG_W];
            end
            if (w_strb_q[1]) begin
                g_dir_q <= w_data_q[G_DIR_LSB +: PG_W];
            end
            if (w_strb_q[2]) begin
                async_timer_clock_select <= w_data_q[ASYNC_BIT];
                ext_memory_enable <= w_data_q[EXTMEM_BIT];
            end
        end
    end

    // Read channel: one read at a time, answered the cycle after it is taken.
    assign ar_take = s_axi_arvalid & s_axi_arready;
    assign rvalid_d = ar_take | (s_axi_rvalid & ~s_axi_rready);
    assign rd_hit = idx_mapped(s_axi_araddr[7:2]);
    // Gated port G inputs read as zero so the oscillator is never sensed.
    assign g_pin_read = pins_sync[16 +: PG_W] & port_g_in_en;

    always_comb begin
        rd_data_d = 32'h0000_0000;
        case (s_axi_araddr[7:2])
            IDX_A_OUT: rd_data_d[7:0] = a_out_q;
            IDX_A_DIR: rd_data_d[7:0] = a_dir_q;
            IDX_A_PIN: rd_data_d[7:0] = pins_sync[7:0];
            IDX_B_OUT: rd_data_d[7:0] = b_out_q;
            IDX_B_DIR: rd_data_d[7:0] = b_dir_q;
            IDX_B_PIN: rd_data_d[7:0] = pins_sync[15:8];
            IDX_C_OUT: rd_data_d[7:0] = c_out_q;
            IDX_C_DIR: rd_data_d[7:0] = c_dir_q;
            IDX_G_CTRL: begin
                rd_data_d[G_OUT_LSB +: PG_W] = g_out_q;
                rd_data_d[G_DIR_LSB +: PG_W] = g_dir_q;
                rd_data_d[ASYNC_BIT] = async_timer_clock_select;
                rd_data_d[EXTMEM_BIT] = ext_memory_enable;
            end
            IDX_G_STAT: rd_data_d[PG_W-1:0] = g_pin_read;
            default: rd_data_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= ~rvalid_d;
            s_axi_rvalid <= rvalid_d;
            if (ar_take) begin
                s_axi_rdata <= rd_data_d;
                s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    pio_in_sync #(
        .W(SYNC_W)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .raw({port_g_in, port_b_in, port_a_in}),
        .synced(pins_sync)
    );

    // Override sources: oscillator pins follow the timer clock select,
    // strobe pins follow the external memory enable.
    always_comb begin
        for (int i = 0; i < PG_W; i++) begin
            if (i >= PIN_OSC_IN) begin
                g_ovr.pullup_override_enable[i] = async_timer_clock_select;
                g_ovr.direction_override_enable[i] = async_timer_clock_select;
                g_ovr.pin_value_override_enable[i] = 1'b0;
                g_ovr.input_gate_override_enable[i] = async_timer_clock_select;
                g_ovr.direction_override_value[i] = 1'b0;
            end else begin
                g_ovr.pullup_override_enable[i] = ext_memory_enable;
                g_ovr.direction_override_enable[i] = ext_memory_enable;
                g_ovr.pin_value_override_enable[i] = ext_memory_enable;
                g_ovr.input_gate_override_enable[i] = 1'b0;
                g_ovr.direction_override_value[i] = 1'b1;
            end
            g_ovr.pullup_override_value[i] = 1'b0;
            g_ovr.input_gate_override_value[i] = 1'b0;
        end
        g_ovr.pin_value_override_value = 5'h00;
        g_ovr.pin_value_override_value[PIN_ALE] = ext_latch_strobe;
        g_ovr.pin_value_override_value[PIN_RD] = ext_read_strobe_b;
        g_ovr.pin_value_override_value[PIN_WR] = ext_write_strobe_b;
    end

    pio_pin_cell u_cell (
        .ovr(g_ovr.dst),
        .base_out(g_out_q),
        .base_dir(g_dir_q),
        .pin_out(g_cell_out),
        .pin_oe(g_cell_oe),
        .pin_pullup(g_cell_pullup),
        .pin_in_en(g_cell_in_en)
    );

    // Pin drive is registered, so pins follow the registers one cycle late.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            port_a_out <= PORT_RESET;
            port_a_oe <= PORT_RESET;
            port_a_pullup <= PORT_RESET;
            port_b_out <= PORT_RESET;
            port_b_oe <= PORT_RESET;
            port_b_pullup <= PORT_RESET;
            port_c_out <= PORT_RESET;
            port_c_oe <= PORT_RESET;
            port_c_pullup <= PORT_RESET;
        end else begin
            port_a_out <= a_out_q;
            port_a_oe <= a_dir_q;
            port_a_pullup <= ~a_dir_q & a_out_q;
            port_b_out <= b_out_q;
            port_b_oe <= b_dir_q;
            port_b_pullup <= ~b_dir_q & b_out_q;
            port_c_out <= c_out_q;
            port_c_oe <= c_dir_q;
            port_c_pullup <= ~c_dir_q & c_out_q;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            port_g_out <= PG_RESET;
            port_g_oe <= PG_RESET;
            port_g_pullup <= PG_RESET;
            port_g_in_en <= 5'h1f;
            osc_amp_connect <= 1'b0;
        end else begin
            port_g_out <= g_cell_out;
            port_g_oe <= g_cell_oe;
            port_g_pullup <= g_cell_pullup;
            port_g_in_en <= g_cell_in_en;
            osc_amp_connect <= async_timer_clock_select;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    AST_OSC_IN_DETACH: assert property (
        async_timer_clock_select |=> !port_g_oe[PIN_OSC_IN] && osc_amp_connect)
        else $error("Oscillator input pin still driven as port.");
    AST_OSC_OUT_DETACH: assert property (
        async_timer_clock_select |=> !port_g_oe[PIN_OSC_OUT]
            && !port_g_pullup[PIN_OSC_OUT])
        else $error("Oscillator output pin still driven as port.");
    AST_OSC_NO_SENSE: assert property (
        async_timer_clock_select |=> port_g_in_en[4:3] == 2'b00
            && g_pin_read[4:3] == 2'b00)
        else $error("Oscillator pins still sensed.");
    AST_ALE_PIN: assert property (
        ext_memory_enable |=> port_g_out[PIN_ALE] == $past(ext_latch_strobe)
            && port_g_oe[PIN_ALE])
        else $error("Latch strobe not on its pin.");
    AST_RD_PIN: assert property (
        ext_memory_enable |=> port_g_out[PIN_RD] == $past(ext_read_strobe_b))
        else $error("Read strobe not on its pin.");
    AST_WR_PIN: assert property (
        ext_memory_enable |=> port_g_out[PIN_WR] == $past(ext_write_strobe_b))
        else $error("Write strobe not on its pin.");
    AST_OSC_VALUE: assert property (
        async_timer_clock_select && !ext_memory_enable
            |=> port_g_out[4:3] == $past(g_out_q[4:3]))
        else $error("Oscillator pin value was overridden.");
    AST_STROBE_PINS: assert property (
        ext_memory_enable |=> port_g_pullup[2:1] == 2'b00
            && port_g_in_en[2:1] == 2'b11)
        else $error("Latch or read pin override wrong.");
    AST_WR_GATE: assert property (
        ext_memory_enable |=> port_g_in_en[PIN_WR] && port_g_oe[PIN_WR]
            && !port_g_pullup[PIN_WR])
        else $error("Write pin override wrong.");
    AST_DIR_WRITE: assert property (
        wr_do && w_strb_q[0] && aw_idx_q == IDX_A_DIR
            |=> a_dir_q == $past(w_data_q[7:0]) ##1 port_a_oe == a_dir_q)
        else $error("Direction write not applied.");
    AST_PIN_RO: assert property (
        wr_do && aw_idx_q == IDX_A_PIN |=> $stable(a_out_q) && $stable(a_dir_q))
        else $error("Pin input write stored a value.");
    AST_DRIVE: assert property (
        1'b1 |=> port_b_oe == $past(b_dir_q) && port_b_out == $past(b_out_q))
        else $error("Port drive does not follow registers.");

    COV_WRITE: cover property (wr_do ##1 s_axi_bvalid);
    COV_READ_PIN: cover property (ar_take && s_axi_araddr[7:2] == IDX_B_PIN);
    COV_BOTH_MODES: cover property (
        async_timer_clock_select && ext_memory_enable);
endmodule : pio_port_top

// ==== pio_far_model.sv ====
// Far-side model: board pins, memory strobes and timer crystal.
`timescale 1ns/1ps
module pio_far_model
    import pio_pkg::*;
(
    input wire logic clk_sys,
    input wire logic [PORT_W-1:0] port_a_out,
    input wire logic [PORT_W-1:0] port_a_oe,
    input wire logic [PORT_W-1:0] port_b_out,
    input wire logic [PORT_W-1:0] port_b_oe,
    input wire logic [PG_W-1:0] port_g_out,
    input wire logic [PG_W-1:0] port_g_oe,
    input wire logic [PORT_W-1:0] a_drv,
    input wire logic [PORT_W-1:0] b_drv,
    output logic [PORT_W-1:0] port_a_in,
    output logic [PORT_W-1:0] port_b_in,
    output logic [PG_W-1:0] port_g_in,
    output logic ext_latch_strobe,
    output logic ext_read_strobe_b,
    output logic ext_write_strobe_b
);
    logic [2:0] cnt_q = 3'h0;
    // The strobe triple changes every cycle, so a stale or swapped copy shows at once.
    always @(posedge clk_sys) cnt_q <= cnt_q + 3'h1;
    assign {ext_latch_strobe, ext_read_strobe_b, ext_write_strobe_b} = cnt_q;
    // An undriven pin follows the board driver, not the port's own latch.
    assign port_a_in = (port_a_out & port_a_oe) | (a_drv & ~port_a_oe);
    assign port_b_in = (port_b_out & port_b_oe) | (b_drv & ~port_b_oe);
    // The crystal keeps swinging whether or not the port listens.
    assign port_g_in = (port_g_out & port_g_oe) | ({cnt_q[1:0], 3'h0} & ~port_g_oe);
endmodule : pio_far_model

// ==== tb.sv ====
// Self-checking bench for the port I/O block.
`timescale 1ns/1ps
module tb;
    import pio_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata, rd_q;
    logic [7:0] port_a_in, port_a_out, port_a_oe, port_a_pullup;
    logic [7:0] port_b_in, port_b_out, port_b_oe, port_b_pullup;
    logic [7:0] port_c_out, port_c_oe, port_c_pullup;
    logic [7:0] a_drv = 8'h96, b_drv = 8'h69;
    logic [4:0] port_g_in, port_g_out, port_g_oe, port_g_pullup, port_g_in_en;
    logic ext_latch_strobe, ext_read_strobe_b, ext_write_strobe_b;
    logic osc_amp_connect;
    logic [2:0] s;
    int bad_count = 0, compares = 0;
    logic [5:0] rw_idx [6] = '{IDX_C_DIR, IDX_C_OUT, IDX_B_DIR, IDX_B_OUT,
                               IDX_A_DIR, IDX_A_OUT};
    pio_port_top dut (
        .clk_sys, .rst_b, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .port_a_in, .port_a_out, .port_a_oe, .port_a_pullup, .port_b_in,
        .port_b_out, .port_b_oe, .port_b_pullup, .port_c_out, .port_c_oe,
        .port_c_pullup, .port_g_in, .port_g_out, .port_g_oe, .port_g_pullup,
        .port_g_in_en, .ext_latch_strobe, .ext_read_strobe_b,
        .ext_write_strobe_b, .osc_amp_connect
    );
    pio_far_model far (
        .clk_sys, .port_a_out, .port_a_oe, .port_b_out, .port_b_oe,
        .port_g_out, .port_g_oe, .a_drv, .b_drv, .port_a_in, .port_b_in,
        .port_g_in, .ext_latch_strobe, .ext_read_strobe_b, .ext_write_strobe_b
    );
    initial forever #2 clk_sys = ~clk_sys;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string m);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s got %h want %h", $time, m, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd_q = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic end_sim;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim
    initial begin
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        foreach (rw_idx[i]) begin
            rd({rw_idx[i], 2'b00});
            chk(rd_q, 32'h0, "reset value");
        end
        $display("test reset done");
        foreach (rw_idx[i]) wr({rw_idx[i], 2'b00}, i[0] ? 32'h3c : 32'h0f);
        foreach (rw_idx[i]) begin
            rd({rw_idx[i], 2'b00});
            chk(rd_q, i[0] ? 32'h3c : 32'h0f, "readback");
        end
        chk({port_a_out, port_a_oe, port_a_pullup}, 32'h3c0f30, "port a");
        chk({port_b_out, port_b_oe, port_b_pullup}, 32'h3c0f30, "port b");
        chk({port_c_out, port_c_oe, port_c_pullup}, 32'h3c0f30, "port c");
        $display("test registers done");
        rd({IDX_A_PIN, 2'b00});
        chk(rd_q, 32'h9c, "pin a");
        rd({IDX_B_PIN, 2'b00});
        chk(rd_q, 32'h6c, "pin b");
        wr({IDX_A_PIN, 2'b00}, 32'h55);
        chk(rsp, RESP_OKAY, "pin write");
        rd({IDX_A_PIN, 2'b00});
        chk(rd_q, 32'h9c, "pin after write");
        rd(8'hfc);
        chk({rd_q[29:0], rsp}, RESP_SLVERR, "unmapped read");
        wr(8'hfc, 32'h0000_00ff);
        chk(rsp, RESP_SLVERR, "unmapped write");
        $display("test pins done");
        wr({IDX_G_CTRL, 2'b00}, 32'h0002001f);
        repeat (2) @(negedge clk_sys);
        repeat (3) begin
            @(negedge clk_sys);
            s = {ext_latch_strobe, ext_read_strobe_b, ext_write_strobe_b};
            @(negedge clk_sys);
            chk(port_g_out[2:0], s, "strobe");
        end
        chk({port_g_oe, port_g_pullup, port_g_in_en}, {5'h07, 5'h18, 5'h1f},
            "memory pins");
        $display("test memory done");
        wr({IDX_G_CTRL, 2'b00}, 32'h00011f1f);
        repeat (4) @(negedge clk_sys);
        chk({osc_amp_connect, port_g_oe, port_g_pullup, port_g_in_en, port_g_out},
            {1'b1, 5'h07, 5'h00, 5'h07, 5'h1f}, "osc pins");
        rd({IDX_G_STAT, 2'b00});
        chk(rd_q, 32'h07, "osc sense");
        $display("test oscillator done");
        rst_b <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        rd({IDX_A_OUT, 2'b00});
        chk({rd_q[30:0], osc_amp_connect}, 32'h0, "second reset");
        $display("test second reset done");
        end_sim;
    end
    // Whole run needs little over a hundred cycles; this only cuts a hang short.
    initial begin
        repeat (20000) @(posedge clk_sys);
        bad_count++;
        end_sim;
    end
endmodule : tb
